// *** verilog/mfc_counter_ctrl.sv ***
// Measurement sequencing, panel lamps and register slave of the multifunction counter
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - After reset the low-band frequency mode is selected, shown in kilohertz.
// - After reset the shortest resolution is selected: 0.01s gate, single period.
// - Mode button press advances among six modes; only that mode's lamp lights.
// - Low and mid band gates are 0.01s, 0.1s, 1.0s and 10s.
// - High band gates are 25.6ms..25.6s crystal, 32ms..32s compensated base.
// - Period mode averages over 1, 10, 100 or 1000 input cycles.
// - Only high-band mode uses the secondary input; self-check counts the clock, others use the primary.
// - Accumulate mode counts primary cycles and shows the running count.
// - Accumulation stops while the gate input is low; high allows counting.
// - Freeze outside accumulation holds display, clears counter, restarts on release.
// - Freeze in accumulation holds display, pauses; resumes only if gate high.
// - Clear button zeroes the count; a fresh measurement starts on release.
// - Activity lamp is lit exactly while a measurement is in progress.
// - Results beyond eight digits light overflow lamp and drop top digits.
// - Kilo lamp in low, self-check, period; mega in mid, high; none accumulating.
// - Self-check mode measures the internal reference time base frequency.
// - Resolution button steps four settings with lamps; when accumulating it steps without restarting the count.
// - Low band above 10 Mega_unit_lamp may read zero without the overflow lamp.
// - Decimal point position follows the selected resolution setting, fixed at zero when accumulating.
module mfc_counter_ctrl #(
    parameter longint LB_GATE_CYCLES = mfc_pkg::LB_GATE_CYC,
    parameter longint HB_XTAL_GATE_CYCLES = mfc_pkg::HB_XTAL_GATE_CYC,
    parameter longint HB_COMP_GATE_CYCLES = mfc_pkg::HB_COMP_GATE_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic primary_signal_in,
    input wire logic secondary_signal_in,
    input wire logic mode_select_button_in,
    input wire logic resolution_select_button_in,
    input wire logic clear_button_in,
    input wire logic display_freeze_switch_in,
    input wire logic accumulate_gate_input_in,
    input wire mfc_pkg::mfc_axi_req_type axi_req_in,
    output mfc_pkg::mfc_axi_rsp_type axi_rsp_out,
    output logic [5:0] mode_lamps_out,
    output logic [3:0] resolution_lamps_out,
    output logic activity_lamp_out,
    output logic range_exceeded_lamp_out,
    output logic kilo_micro_unit_lamp_out,
    output logic mega_unit_lamp_out,
    output logic [26:0] display_value_out,
    output logic [2:0] decimal_point_out
);
    typedef struct packed {
        logic [2:0] pri_s;
        logic [2:0] sec_s;
        logic [1:0] gate_s;
        logic [1:0] frz_s;
        logic [1:0] clr_s;
        logic [2:0] mode_btn_s;
        logic [2:0] res_btn_s;
        mfc_pkg::mfc_mode_type mode;
        logic [1:0] res;
        logic comp_tb;
        mfc_pkg::mfc_meas_type st;
        logic [35:0] gate_cnt;
        logic [35:0] event_cnt;
        logic [26:0] display;
        logic overflow;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mfc_state_type;

    mfc_state_type q, d;

    function automatic logic [35:0] decade(input logic [35:0] base, input logic [1:0] res);
        case (res)
            2'h0: decade = base;
            2'h1: decade = 36'(base * 36'd10);
            2'h2: decade = 36'(base * 36'd100);
            default: decade = 36'(base * 36'd1000);
        endcase
    endfunction

    // Eight digits only; leading digits are simply lost
    function automatic logic [27:0] fit_display(input logic [35:0] value);
        logic [35:0] rem;
        rem = value % mfc_pkg::DISPLAY_LIMIT;
        fit_display = {(value >= mfc_pkg::DISPLAY_LIMIT), rem[26:0]};
    endfunction

    function automatic mfc_pkg::mfc_meas_type start_state(input mfc_pkg::mfc_mode_type mode);
        // Period timing must align to an input edge first
        start_state = (mode == mfc_pkg::MODE_PERIOD) ? mfc_pkg::MS_ARM : mfc_pkg::MS_RUN;
    endfunction

    logic pri_edge, sec_edge, gate_hi, frozen, clearing, mode_press, res_press;
    logic src_edge, freq_mode, gate_done, period_done;
    logic [35:0] gate_target, period_target, result;
    logic [27:0] fitted, acc_fit;
    logic [31:0] status_word, read_word;
    logic read_ok;

    always_comb
    begin
        pri_edge = q.pri_s[1] & ~q.pri_s[2];
        sec_edge = q.sec_s[1] & ~q.sec_s[2];
        gate_hi = q.gate_s[1];
        frozen = q.frz_s[1];
        clearing = q.clr_s[1];
        mode_press = q.mode_btn_s[1] & ~q.mode_btn_s[2];
        res_press = q.res_btn_s[1] & ~q.res_btn_s[2];
        freq_mode = (q.mode != mfc_pkg::MODE_PERIOD) && (q.mode != mfc_pkg::MODE_ACCUMULATE);
        case (q.mode)
            mfc_pkg::MODE_HIGH_BAND: src_edge = sec_edge;
            mfc_pkg::MODE_SELFCHECK: src_edge = 1'b1;
            default: src_edge = pri_edge;
        endcase
        if (q.mode == mfc_pkg::MODE_HIGH_BAND)
        begin
            gate_target = decade(q.comp_tb ? 36'(HB_COMP_GATE_CYCLES) : 36'(HB_XTAL_GATE_CYCLES), q.res);
        end
        else
        begin
            gate_target = decade(36'(LB_GATE_CYCLES), q.res);
        end
        period_target = decade(36'd1, q.res);
        gate_done = freq_mode && (q.st == mfc_pkg::MS_RUN) && (q.gate_cnt == gate_target - 36'd1);
        period_done = (q.mode == mfc_pkg::MODE_PERIOD) && (q.st == mfc_pkg::MS_RUN) && pri_edge
            && (q.event_cnt + 36'd1 == period_target);
        if (q.mode == mfc_pkg::MODE_PERIOD)
        begin
            result = q.gate_cnt + 36'd1;
        end
        else
        begin
            result = q.event_cnt + {35'h0, src_edge};
        end
        fitted = fit_display(result);
        acc_fit = fit_display(q.event_cnt + {35'h0, gate_hi & pri_edge});
        // Above the guaranteed low-band range the reading collapses to zero
        if (q.mode == mfc_pkg::MODE_LOW_BAND && result > decade(mfc_pkg::LB_LIMIT_COUNT, q.res))
        begin
            fitted = 28'h0;
        end
    end

    always_comb
    begin
        status_word = 32'h0;
        status_word[2:0] = 3'(q.mode);
        status_word[mfc_pkg::ST_RES_LSB +: 2] = q.res;
        status_word[mfc_pkg::ST_ACTIVE_BIT] = activity_lamp_out;
        status_word[mfc_pkg::ST_OVF_BIT] = q.overflow;
        status_word[mfc_pkg::ST_FROZEN_BIT] = frozen;
        read_ok = 1'b1;
        case (axi_req_in.araddr)
            mfc_pkg::REG_CONFIG: read_word = {31'h0, q.comp_tb};
            mfc_pkg::REG_STATUS: read_word = status_word;
            mfc_pkg::REG_DISPLAY: read_word = {5'h0, q.display};
            mfc_pkg::REG_COUNT: read_word = q.event_cnt[31:0];
            default:
            begin
                read_word = 32'h0;
                read_ok = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        d = q;
        d.pri_s = {q.pri_s[1:0], primary_signal_in};
        d.sec_s = {q.sec_s[1:0], secondary_signal_in};
        d.gate_s = {q.gate_s[0], accumulate_gate_input_in};
        d.frz_s = {q.frz_s[0], display_freeze_switch_in};
        d.clr_s = {q.clr_s[0], clear_button_in};
        d.mode_btn_s = {q.mode_btn_s[1:0], mode_select_button_in};
        d.res_btn_s = {q.res_btn_s[1:0], resolution_select_button_in};

        if (clearing)
        begin
            // Clear has priority over the buttons, freeze and counting (not reset or the register slave) and blanks the reading
            d.st = mfc_pkg::MS_HALT;
            d.gate_cnt = 36'h0;
            d.event_cnt = 36'h0;
            d.display = 27'h0;
            d.overflow = 1'b0;
        end
        else if (mode_press || (res_press && q.mode != mfc_pkg::MODE_ACCUMULATE))
        begin
            if (mode_press)
            begin
                d.mode = (q.mode == mfc_pkg::MODE_SELFCHECK) ? mfc_pkg::MODE_LOW_BAND
                    : mfc_pkg::mfc_mode_type'(3'(q.mode) + 3'h1);
            end
            else
            begin
                d.res = q.res + 2'h1;
            end
            d.gate_cnt = 36'h0;
            d.event_cnt = 36'h0;
            d.st = frozen ? mfc_pkg::MS_HALT : start_state(mode_press ? d.mode : q.mode);
        end
        else if (q.mode == mfc_pkg::MODE_ACCUMULATE)
        begin
            if (res_press)
            begin
                d.res = q.res + 2'h1;
            end
            if (frozen)
            begin
                d.st = mfc_pkg::MS_HALT;
            end
            else
            begin
                d.st = mfc_pkg::MS_RUN;
                if (gate_hi && pri_edge)
                begin
                    d.event_cnt = q.event_cnt + 36'd1;
                end
                d.display = acc_fit[26:0];
                d.overflow = acc_fit[27];
            end
        end
        else if (frozen)
        begin
            d.st = mfc_pkg::MS_HALT;
            d.gate_cnt = 36'h0;
            d.event_cnt = 36'h0;
        end
        else
        begin
            case (q.st)
                mfc_pkg::MS_HALT:
                begin
                    // Release of clear or freeze starts afresh
                    d.st = start_state(q.mode);
                    d.gate_cnt = 36'h0;
                    d.event_cnt = 36'h0;
                end
                mfc_pkg::MS_ARM:
                begin
                    if (pri_edge)
                    begin
                        d.st = mfc_pkg::MS_RUN;
                        d.gate_cnt = 36'h0;
                        d.event_cnt = 36'h0;
                    end
                end
                mfc_pkg::MS_RUN:
                begin
                    if (gate_done || period_done)
                    begin
                        d.display = fitted[26:0];
                        d.overflow = fitted[27];
                        d.gate_cnt = 36'h0;
                        d.event_cnt = 36'h0;
                    end
                    else
                    begin
                        d.gate_cnt = q.gate_cnt + 36'd1;
                        if (freq_mode ? src_edge : pri_edge)
                        begin
                            d.event_cnt = q.event_cnt + 36'd1;
                        end
                    end
                end
                default: d.st = mfc_pkg::MS_HALT;
            endcase
        end

        // Register slave: address and data may come in either order
        if (axi_req_in.awvalid && axi_rsp_out.awready)
        begin
            d.aw_held = 1'b1;
            d.aw_addr = axi_req_in.awaddr;
        end
        if (axi_req_in.wvalid && axi_rsp_out.wready)
        begin
            d.w_held = 1'b1;
            d.w_data = axi_req_in.wdata;
            d.w_strb = axi_req_in.wstrb;
        end
        if (q.aw_held && q.w_held && !q.bvalid)
        begin
            d.aw_held = 1'b0;
            d.w_held = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = mfc_pkg::RESP_OKAY;
            if (q.aw_addr == mfc_pkg::REG_CONFIG)
            begin
                if (q.w_strb[0])
                begin
                    d.comp_tb = q.w_data[mfc_pkg::CFG_COMP_TB_BIT];
                end
            end
            else if (q.aw_addr != mfc_pkg::REG_STATUS && q.aw_addr != mfc_pkg::REG_DISPLAY
                && q.aw_addr != mfc_pkg::REG_COUNT)
            begin
                d.bresp = mfc_pkg::RESP_SLVERR;
            end
        end
        if (q.bvalid && axi_req_in.bready)
        begin
            d.bvalid = 1'b0;
        end
        if (axi_req_in.arvalid && axi_rsp_out.arready)
        begin
            d.rvalid = 1'b1;
            d.rdata = read_word;
            d.rresp = read_ok ? mfc_pkg::RESP_OKAY : mfc_pkg::RESP_SLVERR;
        end
        else if (q.rvalid && axi_req_in.rready)
        begin
            d.rvalid = 1'b0;
        end

        if (!rst_n_in)
        begin
            d = '0;
            d.mode = mfc_pkg::RST_MODE;
            d.res = mfc_pkg::RST_RES;
            d.comp_tb = mfc_pkg::RST_COMP_TB;
            d.st = mfc_pkg::MS_RUN;
        end
    end

    always_ff @(posedge clk_in)
    begin
        q <= d;
    end

    always_comb
    begin
        axi_rsp_out.awready = !q.aw_held;
        axi_rsp_out.wready = !q.w_held;
        axi_rsp_out.bvalid = q.bvalid;
        axi_rsp_out.bresp = q.bresp;
        axi_rsp_out.arready = !q.rvalid;
        axi_rsp_out.rvalid = q.rvalid;
        axi_rsp_out.rdata = q.rdata;
        axi_rsp_out.rresp = q.rresp;
        mode_lamps_out = 6'h1 << 3'(q.mode);
        resolution_lamps_out = 4'h1 << q.res;
        activity_lamp_out = (q.st != mfc_pkg::MS_HALT)
            && (q.mode != mfc_pkg::MODE_ACCUMULATE || gate_hi);
        range_exceeded_lamp_out = q.overflow;
        kilo_micro_unit_lamp_out = (q.mode == mfc_pkg::MODE_LOW_BAND) || (q.mode == mfc_pkg::MODE_PERIOD)
            || (q.mode == mfc_pkg::MODE_SELFCHECK);
        mega_unit_lamp_out = (q.mode == mfc_pkg::MODE_MID_BAND)
            || (q.mode == mfc_pkg::MODE_HIGH_BAND);
        display_value_out = q.display;
        case (q.mode)
            mfc_pkg::MODE_MID_BAND: decimal_point_out = 3'(q.res) + 3'h3;
            mfc_pkg::MODE_HIGH_BAND: decimal_point_out = 3'(q.res) + 3'h2;
            mfc_pkg::MODE_ACCUMULATE: decimal_point_out = 3'h0;
            default: decimal_point_out = 3'(q.res) + 3'h1;
        endcase
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    reset_defaults_a: assert property ($rose(rst_n_in) |-> q.mode == mfc_pkg::MODE_LOW_BAND && q.res == 2'h0
        && kilo_micro_unit_lamp_out) else $error("reset did not select low band, shortest gate");
    reset_res_a: assert property ($rose(rst_n_in) |-> resolution_lamps_out == 4'h1)
        else $error("reset did not light first resolution lamp");
    mode_step_a: assert property (mode_press && !clearing && q.mode != mfc_pkg::MODE_SELFCHECK
        |=> 3'(q.mode) == 3'($past(q.mode)) + 3'h1 && $onehot(mode_lamps_out)) else $error("mode did not advance");
    gate_length_a: assert property (gate_done && !clearing && !frozen && !mode_press && !res_press
        |=> q.gate_cnt == 36'h0 && q.st == mfc_pkg::MS_RUN) else $error("gate did not restart");
    freeze_hold_a: assert property (frozen && !clearing && $past(frozen) |=> $stable(display_value_out))
        else $error("display moved while frozen");
    clear_zero_a: assert property (clearing |=> display_value_out == 27'h0 && q.event_cnt == 36'h0
        && !activity_lamp_out) else $error("clear did not zero the count");
    acc_gate_a: assert property (q.mode == mfc_pkg::MODE_ACCUMULATE && !gate_hi && !clearing && !mode_press
        |=> $stable(q.event_cnt)) else $error("accumulated while gate low");
    unit_lamp_a: assert property (q.mode == mfc_pkg::MODE_ACCUMULATE |-> !kilo_micro_unit_lamp_out
        && !mega_unit_lamp_out) else $error("unit lamp lit while accumulating");
    display_range_a: assert property (display_value_out < 27'(mfc_pkg::DISPLAY_LIMIT))
        else $error("display beyond eight digits");
    period_len_a: assert property (period_done && !clearing && !frozen && !mode_press && !res_press
        |=> display_value_out == 27'($past(q.gate_cnt) + 36'd1)) else $error("period result wrong");

    freq_done_c: cover property (gate_done && q.mode == mfc_pkg::MODE_MID_BAND);
    period_done_c: cover property (period_done && q.res == 2'h1);
    acc_count_c: cover property (q.mode == mfc_pkg::MODE_ACCUMULATE && gate_hi && pri_edge);
    overflow_c: cover property ($rose(range_exceeded_lamp_out));
endmodule

`default_nettype wire

// *** verilog/mfc_pkg.sv ***
// Shared constants and types for the multifunction counter control block
package mfc_pkg;
    typedef enum logic [2:0] {
        MODE_LOW_BAND,
        MODE_MID_BAND,
        MODE_HIGH_BAND,
        MODE_PERIOD,
        MODE_ACCUMULATE,
        MODE_SELFCHECK
    } mfc_mode_type;

    typedef enum logic [1:0] {
        MS_HALT,
        MS_ARM,
        MS_RUN
    } mfc_meas_type;

    localparam int CLK_PERIOD_NS = 5;
    localparam longint LB_GATE_NS = 64'd10_000_000;
    localparam longint HB_XTAL_GATE_NS = 64'd25_600_000;
    localparam longint HB_COMP_GATE_NS = 64'd32_000_000;
    localparam longint LB_GATE_CYC = LB_GATE_NS / CLK_PERIOD_NS;
    localparam longint HB_XTAL_GATE_CYC = HB_XTAL_GATE_NS / CLK_PERIOD_NS;
    localparam longint HB_COMP_GATE_CYC = HB_COMP_GATE_NS / CLK_PERIOD_NS;
    localparam longint LOW_BAND_LIMIT_HZ = 64'd10_000_000;
    localparam logic [35:0] LB_LIMIT_COUNT = 36'(LOW_BAND_LIMIT_HZ * LB_GATE_NS / 64'd1_000_000_000);
    localparam logic [35:0] DISPLAY_LIMIT = 36'd100_000_000;

    localparam mfc_mode_type RST_MODE = MODE_LOW_BAND;
    localparam logic [1:0] RST_RES = 2'h0;
    localparam logic RST_COMP_TB = 1'b0;

    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DISPLAY = 8'h08;
    localparam logic [7:0] REG_COUNT = 8'h0c;
    localparam int CFG_COMP_TB_BIT = 0;
    localparam int ST_RES_LSB = 4;
    localparam int ST_ACTIVE_BIT = 8;
    localparam int ST_OVF_BIT = 9;
    localparam int ST_FROZEN_BIT = 10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } mfc_axi_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mfc_axi_rsp_type;
endpackage

// *** verification/mfc_panel_model.sv ***
// Far-side model: measured inputs and the rear gate line
`timescale 1ns/10ps
`default_nettype none
module mfc_panel_model (
    input wire logic clk_in,
    input wire logic [7:0] prim_half_in,
    input wire logic [7:0] sec_half_in,
    input wire logic gate_drive_in,
    input wire logic gate_level_in,
    output logic primary_out,
    output logic secondary_out,
    output logic gate_out
);
    logic [7:0] pc_q = 8'h00;
    logic [7:0] sc_q = 8'h00;
    logic p_q = 1'b0;
    logic s_q = 1'b0;
    assign primary_out = p_q;
    assign secondary_out = s_q;
    // Open jack reads high through the pull-up
    assign gate_out = gate_drive_in ? gate_level_in : 1'b1;
    always @(posedge clk_in)
    begin
        pc_q <= (pc_q + 8'h01 >= prim_half_in) ? 8'h00 : pc_q + 8'h01;
        sc_q <= (sc_q + 8'h01 >= sec_half_in) ? 8'h00 : sc_q + 8'h01;
        if (pc_q + 8'h01 >= prim_half_in)
            p_q <= ~p_q;
        if (sc_q + 8'h01 >= sec_half_in)
            s_q <= ~s_q;
    end
endmodule
`default_nettype wire

// *** verification/mfc_counter_ctrl_bench.sv ***
// Self-checking bench of the counter control block
`timescale 1ns/10ps
`default_nettype none
module mfc_counter_ctrl_bench;
    localparam longint LB = 20;
    localparam longint HBX = 26;
    localparam longint HBC = 32;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic mode_b = 1'b0, res_b = 1'b0, clr = 1'b0, frz = 1'b0;
    logic [7:0] ph = 8'h02, sh = 8'h01;
    logic gdrv = 1'b0, glvl = 1'b1;
    mfc_pkg::mfc_axi_req_type ax = '0;
    mfc_pkg::mfc_axi_rsp_type rsp;
    wire logic prim, sec, gate;
    logic act, ovf, kilo, mega;
    logic [5:0] ml;
    logic [3:0] rl;
    logic [26:0] dv, d1;
    logic [2:0] dp;
    logic [31:0] rd, seed = 32'h00016808;
    logic [1:0] rr;
    int n_fail = 0, cmp_count = 0, cyc = 0, md = 0, rs = 0;
    always #2.5 clk_in = ~clk_in;
    mfc_panel_model i_mfc_panel_model (.clk_in(clk_in), .prim_half_in(ph), .sec_half_in(sh),
        .gate_drive_in(gdrv), .gate_level_in(glvl), .primary_out(prim), .secondary_out(sec), .gate_out(gate));
    mfc_counter_ctrl #(.LB_GATE_CYCLES(LB), .HB_XTAL_GATE_CYCLES(HBX), .HB_COMP_GATE_CYCLES(HBC))
    i_mfc_counter_ctrl (.clk_in(clk_in), .rst_n_in(rst_n_in), .primary_signal_in(prim),
        .secondary_signal_in(sec), .mode_select_button_in(mode_b), .resolution_select_button_in(res_b),
        .clear_button_in(clr), .display_freeze_switch_in(frz), .accumulate_gate_input_in(gate),
        .axi_req_in(ax), .axi_rsp_out(rsp), .mode_lamps_out(ml), .resolution_lamps_out(rl),
        .activity_lamp_out(act), .range_exceeded_lamp_out(ovf), .kilo_micro_unit_lamp_out(kilo),
        .mega_unit_lamp_out(mega), .display_value_out(dv), .decimal_point_out(dp));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g, input int tol);
        cmp_count++;
        if (^g === 1'bx || (g > e ? g - e : e - g) > tol)
        begin
            n_fail++;
            $display("[FAIL] %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Button held well past the two-flop synchroniser
    task automatic press(input int k);
        @(posedge clk_in);
        mode_b <= (k == 0);
        res_b <= (k != 0);
        tk(4);
        mode_b <= 1'b0;
        res_b <= 1'b0;
        tk(4);
        if (k == 0)
            md = (md + 1) % 6;
        else
            rs = (rs + 1) % 4;
        chk("mode lamps", 32'(6'h01 << md), 32'(ml), 0);
        chk("res lamps", 32'(4'h1 << rs), 32'(rl), 0);
        chk("kilo lamp", 32'(md == 0 || md == 3 || md == 5), 32'(kilo), 0);
        chk("mega lamp", 32'(md == 1 || md == 2), 32'(mega), 0);
        chk("point", md == 1 ? rs + 3 : md == 2 ? rs + 2 : md == 4 ? 0 : rs + 1, 32'(dp), 0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge clk_in);
        ax.awvalid <= 1'b1;
        ax.awaddr <= a;
        ax.wvalid <= 1'b1;
        ax.wdata <= d;
        ax.wstrb <= 4'hf;
        ax.bready <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (aw && rsp.awready)
            begin
                aw = 1'b0;
                ax.awvalid <= 1'b0;
            end
            if (w && rsp.wready)
            begin
                w = 1'b0;
                ax.wvalid <= 1'b0;
            end
            if (rsp.bvalid)
                ax.bready <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
    endtask
    task automatic rdr(input logic [7:0] a);
        logic ar;
        ar = 1'b1;
        @(posedge clk_in);
        ax.arvalid <= 1'b1;
        ax.araddr <= a;
        ax.rready <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (ar && rsp.arready)
            begin
                ar = 1'b0;
                ax.arvalid <= 1'b0;
            end
            rd = rsp.rdata;
            rr = rsp.rresp;
            if (rsp.rvalid)
                ax.rready <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
    endtask
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            n_fail++;
            conclude();
        end
    end
    initial
    begin
        tk(8);
        rst_n_in <= 1'b1;
        tk(4);
        chk("mode lamps", 32'h1, 32'(ml), 0);
        chk("res lamps", 32'h1, 32'(rl), 0);
        chk("kilo lamp", 32'h1, 32'(kilo), 0);
        chk("activity", 32'h1, 32'(act), 0);
        tk(int'(2 * LB + 10));
        chk("low band", 32'(LB / 4), 32'(dv), 1);
        chk("no overflow", 32'h0, 32'(ovf), 0);
        repeat (6) press(0);
        seed = xs(seed);
        wr(mfc_pkg::REG_CONFIG, seed);
        rdr(mfc_pkg::REG_CONFIG);
        chk("config", 32'(seed[0]), 32'(rd[0]), 0);
        press(0);
        tk(int'(2 * LB + 10));
        chk("mid band", 32'(LB / 4), 32'(dv), 1);
        press(0);
        tk(int'(2 * HBC + 10));
        chk("high band", 32'((seed[0] ? HBC : HBX) / 2), 32'(dv), 1);
        ph <= 8'h05;
        while (md != 3) press(0);
        tk(60);
        chk("period 1", 32'd10, 32'(dv), 1);
        press(1);
        tk(400);
        chk("period 10", 32'd100, 32'(dv), 1);
        ph <= 8'h02;
        press(0);
        tk(10);
        d1 = dv;
        tk(40);
        chk("accumulate", 32'(d1) + 32'd10, 32'(dv), 1);
        gdrv <= 1'b1;
        glvl <= 1'b0;
        tk(6);
        chk("gate activity", 32'h0, 32'(act), 0);
        d1 = dv;
        tk(40);
        chk("gate low", 32'(d1), 32'(dv), 0);
        gdrv <= 1'b0;
        frz <= 1'b1;
        tk(6);
        d1 = dv;
        tk(40);
        chk("frozen", 32'(d1), 32'(dv), 0);
        frz <= 1'b0;
        tk(46);
        chk("resumed", 32'(d1) + 32'd10, 32'(dv), 2);
        clr <= 1'b1;
        tk(6);
        chk("cleared", 32'h0, 32'(dv), 0);
        clr <= 1'b0;
        tk(46);
        chk("restart", 32'd10, 32'(dv), 2);
        press(0);
        while (rs != 0) press(1);
        for (int r = 0; r < 4; r++)
        begin
            tk(int'(2 * LB * 10 ** r + 10));
            chk("self check", 32'(LB * 10 ** r), 32'(dv), 0);
            press(1);
        end
        tk(50);
        // Resolution stepped while frozen must not reach the display
        frz <= 1'b1;
        press(1);
        tk(500);
        chk("hold", 32'(LB), 32'(dv), 0);
        chk("hold activity", 32'h0, 32'(act), 0);
        frz <= 1'b0;
        tk(20);
        chk("held until done", 32'(LB), 32'(dv), 0);
        tk(int'(20 * LB - 10));
        chk("refresh", 32'(10 * LB), 32'(dv), 0);
        rdr(mfc_pkg::REG_STATUS);
        chk("status mode", 32'(md), 32'(rd[2:0]), 0);
        chk("status res", 32'(rs), 32'(rd[5:4]), 0);
        rdr(8'h10);
        chk("unmapped", 32'(mfc_pkg::RESP_SLVERR), 32'(rr), 0);
        chk("unmapped data", 32'h0, rd, 0);
        conclude();
    end
endmodule
`default_nettype wire
